// file: hdl/fcs_consts.vh
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
`define FCS_UNLOCK1_ADDR 22'h000555
`define FCS_UNLOCK2_ADDR 22'h0002AA
`define FCS_D_UNLOCK1 8'hAA
`define FCS_D_UNLOCK2 8'h55
`define FCS_D_IDREAD 8'h90
`define FCS_D_PROGRAM 8'hA0
`define FCS_D_BYPASS 8'h20
`define FCS_D_ERASE_SETUP 8'h80
`define FCS_D_CHIP_ERASE 8'h10
`define FCS_D_SECTOR_ERASE 8'h30
`define FCS_D_SUSPEND 8'hB0
`define FCS_D_RESUME 8'h30
`define FCS_D_RESET 8'hF0
`define FCS_D_BYPASS_EXIT 8'h00
`define FCS_OFS_MAKER 22'h000000
`define FCS_OFS_DEV1 22'h000001
`define FCS_OFS_DEV2 22'h00000E
`define FCS_OFS_DEV3 22'h00000F
`define FCS_OFS_PROT 22'h000002
`define FCS_OFS_LOCK 22'h000003
`define FCS_BANK_LSB 19
`define FCS_CLK_NS 40
`define FCS_T_WE_NS 120
`define FCS_T_RD_NS 200
`define FCS_T_SUSPEND_US 20
`define FCS_WE_CYC ((`FCS_T_WE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RD_CYC ((`FCS_T_RD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SUSP_CYC (`FCS_T_SUSPEND_US * 1000 / `FCS_CLK_NS)
`endif

// file: hdl/fcs_seq_rom.v
`timescale 1ns/1ns
// sequence memory: per command, up to six address/data steps, registered out
module fcs_seq_rom (
	input wire clk_in,
	input wire [2:0] cmd_in,
	input wire [2:0] step_in,
	output reg [29:0] word_out
);
`include "fcs_consts.vh"
// layout: [29] last step, [28] user address, [27] bank bits from user,
// [26:19] zero, [18:8] low address, [7:0] command data
localparam [21:0] unlock1_addr = `FCS_UNLOCK1_ADDR;
localparam [21:0] unlock2_addr = `FCS_UNLOCK2_ADDR;
reg [29:0] next_word;
always @* begin
	next_word = 30'h0;
	case ({cmd_in, step_in})
	// unlock steps shared by all multi-cycle commands
	6'h08, 6'h10, 6'h18, 6'h20, 6'h28: next_word = {3'h0, 8'h00,
		unlock1_addr[10:0], `FCS_D_UNLOCK1};
	6'h09, 6'h11, 6'h19, 6'h21, 6'h29: next_word = {3'h0, 8'h00,
		unlock2_addr[10:0], `FCS_D_UNLOCK2};
	6'h0A: next_word = {3'h5, 8'h00, unlock1_addr[10:0],
		`FCS_D_IDREAD};
	6'h12: next_word = {3'h0, 8'h00, unlock1_addr[10:0],
		`FCS_D_PROGRAM};
	6'h13: next_word = {3'h6, 8'h00, 11'h000, 8'h00};
	6'h1A: next_word = {3'h4, 8'h00, unlock1_addr[10:0],
		`FCS_D_BYPASS};
	6'h22, 6'h2A: next_word = {3'h0, 8'h00, unlock1_addr[10:0],
		`FCS_D_ERASE_SETUP};
	6'h23, 6'h2B: next_word = {3'h0, 8'h00, unlock1_addr[10:0],
		`FCS_D_UNLOCK1};
	6'h24, 6'h2C: next_word = {3'h0, 8'h00, unlock2_addr[10:0],
		`FCS_D_UNLOCK2};
	6'h25: next_word = {3'h4, 8'h00, unlock1_addr[10:0],
		`FCS_D_CHIP_ERASE};
	6'h2D: next_word = {3'h6, 8'h00, 11'h000,
		`FCS_D_SECTOR_ERASE};
	default: next_word = 30'h0;
	endcase
end
always @(posedge clk_in) begin
	word_out <= next_word;
end
endmodule // fcs_seq_rom

// file: hdl/fcs_host.v
`timescale 1ns/1ns
module fcs_host (
	input wire CLK_IN,
	input wire RESET_IN,
	input wire REQ_IN,
	input wire [3:0] OP_IN,
	input wire [21:0] ADDR_IN,
	input wire [15:0] DATA_IN,
	output reg BUSY_OUT,
	output reg DONE_OUT,
	output reg [15:0] RDATA_OUT,
	output reg FLASH_CE_N_OUT,
	output reg FLASH_WE_N_OUT,
	output reg FLASH_OE_N_OUT,
	output reg [21:0] FLASH_A_OUT,
	output reg [15:0] FLASH_DQ_OUT,
	output reg FLASH_DQ_OE_OUT,
	input wire [15:0] FLASH_DQ_IN,
	input wire READY_BUSY_N_IN,
	output reg READY_OUT,
	output reg SUSPENDED_OUT
);
`include "fcs_consts.vh"
localparam OP_RESET = 4'h0;
localparam OP_IDREAD = 4'h1;
localparam OP_PROGRAM = 4'h2;
localparam OP_BYPASS = 4'h3;
localparam OP_CHIP_ERASE = 4'h4;
localparam OP_SECTOR_ERASE = 4'h5;
localparam OP_BYP_PROGRAM = 4'h6;
localparam OP_BYP_EXIT = 4'h7;
localparam OP_SUSPEND = 4'h8;
localparam OP_RESUME = 4'h9;
localparam OP_READ = 4'hA;
localparam ST_IDLE = 3'd0;
localparam ST_FETCH = 3'd1;
localparam ST_WLOW = 3'd2;
localparam ST_WHIGH = 3'd3;
localparam ST_RLOW = 3'd4;
localparam ST_WAITSUSP = 3'd5;
localparam ST_DONE = 3'd6;
////////////////////////////////////////////////////////////////////////
reg [2:0] state;
reg [3:0] op;
reg [21:0] addr;
reg [15:0] data;
reg [2:0] step;
reg [2:0] cmd;
reg [12:0] cnt;
reg single;
reg [7:0] single_data;
reg [1:0] byp_step;
reg rb_s1, rb_s2, rb_s3;
reg rb_ready;
wire [29:0] rom_word;
// assemble the address of a step from the table and the user address
function [21:0] step_addr;
	input [29:0] w;
	input [21:0] ua;
	begin
		if (w[28])
			step_addr = ua;
		else if (w[27])
			step_addr = {ua[21:`FCS_BANK_LSB], 8'h00, w[18:8]};
		else
			step_addr = {11'h000, w[18:8]};
	end
endfunction
// sequence code for each multi-cycle order except bypass program and bypass exit, which get 0
function [2:0] op_cmd;
	input [3:0] o;
	begin
		case (o)
		OP_IDREAD: op_cmd = 3'd1;
		OP_PROGRAM: op_cmd = 3'd2;
		OP_BYPASS: op_cmd = 3'd3;
		OP_CHIP_ERASE: op_cmd = 3'd4;
		OP_SECTOR_ERASE: op_cmd = 3'd5;
		default: op_cmd = 3'd0;
		endcase
	end
endfunction
fcs_seq_rom u_rom (
	.clk_in(CLK_IN),
	.cmd_in(cmd),
	.step_in(step),
	.word_out(rom_word)
);
////////////////////////////////////////////////////////////////////////
// ready/busy pin crosses in with three flops, change taken when two agree
always @(posedge CLK_IN or posedge RESET_IN) begin
	if (RESET_IN) begin
		rb_s1 <= 1'b1;
		rb_s2 <= 1'b1;
		rb_s3 <= 1'b1;
		rb_ready <= 1'b1;
		READY_OUT <= 1'b1;
	end else begin
		rb_s1 <= READY_BUSY_N_IN;
		rb_s2 <= rb_s1;
		rb_s3 <= rb_s2;
		if (rb_s2 == rb_s3)
			rb_ready <= rb_s3;
		READY_OUT <= rb_ready;
	end
end
////////////////////////////////////////////////////////////////////////
always @(posedge CLK_IN or posedge RESET_IN) begin
	if (RESET_IN) begin
		state <= ST_IDLE;
		op <= 4'h0;
		addr <= 22'h0;
		data <= 16'h0;
		step <= 3'd0;
		cmd <= 3'd0;
		cnt <= 13'd0;
		single <= 1'b0;
		single_data <= 8'h00;
		byp_step <= 2'd0;
		BUSY_OUT <= 1'b0;
		DONE_OUT <= 1'b0;
		RDATA_OUT <= 16'h0;
		FLASH_CE_N_OUT <= 1'b1;
		FLASH_WE_N_OUT <= 1'b1;
		FLASH_OE_N_OUT <= 1'b1;
		FLASH_A_OUT <= 22'h0;
		FLASH_DQ_OUT <= 16'h0;
		FLASH_DQ_OE_OUT <= 1'b0;
		SUSPENDED_OUT <= 1'b0;
	end else begin
		DONE_OUT <= 1'b0;
		case (state)
		ST_IDLE: begin
			BUSY_OUT <= 1'b0;
			if (REQ_IN) begin
				op <= OP_IN;
				addr <= ADDR_IN;
				data <= DATA_IN;
				cmd <= op_cmd(OP_IN);
				step <= 3'd0;
				byp_step <= 2'd0;
				BUSY_OUT <= 1'b1;
				single <= 1'b1;
				case (OP_IN)
				OP_RESET: single_data <= `FCS_D_RESET;
				OP_SUSPEND: single_data <= `FCS_D_SUSPEND;
				OP_RESUME: single_data <= `FCS_D_RESUME;
				OP_BYP_PROGRAM: single_data <= `FCS_D_PROGRAM;
				OP_BYP_EXIT: single_data <= `FCS_D_IDREAD;
				default: single <= 1'b0;
				endcase
				// address settles a cycle before the read strobes fall
				if (OP_IN == OP_READ) begin
					FLASH_A_OUT <= ADDR_IN;
					state <= ST_RLOW;
				end else
					state <= ST_FETCH;
				cnt <= 13'd0;
			end
		end
		ST_FETCH: begin
			// table word for this step is registered one cycle after step
			if (cnt == 13'd1) begin
				cnt <= 13'd0;
				FLASH_CE_N_OUT <= 1'b0;
				FLASH_WE_N_OUT <= 1'b0;
				FLASH_DQ_OE_OUT <= 1'b1;
				if (single) begin
					// bank address carried for suspend and resume
					FLASH_A_OUT <= addr;
					FLASH_DQ_OUT <= {8'h00, single_data};
				end else if (rom_word[28] && !rom_word[29]) begin
					FLASH_A_OUT <= addr;
					FLASH_DQ_OUT <= data;
				end else begin
					FLASH_A_OUT <= step_addr(rom_word, addr);
					FLASH_DQ_OUT <= {8'h00, rom_word[7:0]};
				end
				if (rom_word[28] && (op == OP_PROGRAM ||
					op == OP_BYP_PROGRAM))
					FLASH_DQ_OUT <= data;
				state <= ST_WLOW;
			end else
				cnt <= cnt + 13'd1;
		end
		ST_WLOW: begin
			if (cnt == `FCS_WE_CYC - 1) begin
				cnt <= 13'd0;
				// data latched by the device on this rising edge
				FLASH_WE_N_OUT <= 1'b1;
				FLASH_CE_N_OUT <= 1'b1;
				state <= ST_WHIGH;
			end else
				cnt <= cnt + 13'd1;
		end
		ST_WHIGH: begin
			FLASH_DQ_OE_OUT <= 1'b0;
			if (cnt == `FCS_WE_CYC - 1) begin
				cnt <= 13'd0;
				if (single && (op == OP_BYP_PROGRAM ||
					op == OP_BYP_EXIT) && byp_step == 2'd0) begin
					// second cycle of a bypass pair
					byp_step <= 2'd1;
					single <= (op == OP_BYP_EXIT);
					single_data <= `FCS_D_BYPASS_EXIT;
					cmd <= 3'd2;
					step <= 3'd3;
					state <= ST_FETCH;
				end else if (!single && !rom_word[29]) begin
					step <= step + 3'd1;
					state <= ST_FETCH;
				end else if (op == OP_SUSPEND) begin
					state <= ST_WAITSUSP;
				end else if (op == OP_IDREAD) begin
					FLASH_A_OUT <= addr;
					state <= ST_RLOW;
				end else begin
					if (op == OP_RESUME)
						SUSPENDED_OUT <= 1'b0;
					state <= ST_DONE;
				end
			end else
				cnt <= cnt + 13'd1;
		end
		ST_RLOW: begin
			FLASH_CE_N_OUT <= 1'b0;
			FLASH_OE_N_OUT <= 1'b0;
			FLASH_DQ_OE_OUT <= 1'b0;
			FLASH_A_OUT <= addr;
			if (cnt == `FCS_RD_CYC) begin
				cnt <= 13'd0;
				RDATA_OUT <= FLASH_DQ_IN;
				FLASH_CE_N_OUT <= 1'b1;
				FLASH_OE_N_OUT <= 1'b1;
				state <= ST_DONE;
			end else
				cnt <= cnt + 13'd1;
		end
		ST_WAITSUSP: begin
			// allow the device its full suspend time before reporting
			if (cnt == `FCS_SUSP_CYC) begin
				cnt <= 13'd0;
				SUSPENDED_OUT <= 1'b1;
				state <= ST_DONE;
			end else
				cnt <= cnt + 13'd1;
		end
		ST_DONE: begin
			DONE_OUT <= 1'b1;
			BUSY_OUT <= 1'b0;
			state <= ST_IDLE;
		end
		default: state <= ST_IDLE;
		endcase
	end
end
endmodule // fcs_host

// file: dv/fcs_checker.sv
`timescale 1ns/1ns
module fcs_checker (
	input wire CLK_IN,
	input wire RESET_IN,
	input wire REQ_IN,
	input wire BUSY_OUT,
	input wire DONE_OUT,
	input wire FLASH_WE_N_OUT,
	input wire FLASH_OE_N_OUT,
	input wire [15:0] FLASH_DQ_OUT,
	input wire FLASH_DQ_OE_OUT,
	input wire READY_BUSY_N_IN,
	input wire READY_OUT,
	input wire SUSPENDED_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RESET_IN);
	a_done_one_cycle: assert property (DONE_OUT |=> !DONE_OUT)
		else $error("done longer than one cycle");
	a_req_sets_busy: assert property (REQ_IN && !BUSY_OUT |=> BUSY_OUT)
		else $error("order not taken");
	a_done_ends_busy: assert property (DONE_OUT |-> ##[0:1] !BUSY_OUT)
		else $error("busy after done");
	a_we_low_width: assert property ($fell(FLASH_WE_N_OUT) |->
		!FLASH_WE_N_OUT [*3] ##1 FLASH_WE_N_OUT) else $error("we width");
	a_write_drives_dq: assert property (!FLASH_WE_N_OUT |->
		FLASH_DQ_OE_OUT && FLASH_OE_N_OUT) else $error("write not driven");
	a_suspend_in_time: assert property ($rose(FLASH_WE_N_OUT) &&
		FLASH_DQ_OE_OUT && FLASH_DQ_OUT[7:0] == 8'hB0 |->
		##[1:520] SUSPENDED_OUT) else $error("suspend flag late");
	a_resume_clears: assert property ($rose(FLASH_WE_N_OUT) &&
		FLASH_DQ_OE_OUT && SUSPENDED_OUT && FLASH_DQ_OUT[7:0] == 8'h30
		|-> ##[1:12] !SUSPENDED_OUT) else $error("suspend flag kept");
	a_busy_pin_seen: assert property ((!READY_BUSY_N_IN) [*8] |->
		!READY_OUT) else $error("busy pin not seen");
endmodule // fcs_checker
bind fcs_host fcs_checker u_chk (.CLK_IN, .RESET_IN, .REQ_IN, .BUSY_OUT,
	.DONE_OUT, .FLASH_WE_N_OUT, .FLASH_OE_N_OUT, .FLASH_DQ_OUT,
	.FLASH_DQ_OE_OUT, .READY_BUSY_N_IN, .READY_OUT, .SUSPENDED_OUT);

// file: dv/fcs_flash_model.sv
`timescale 1ns/1ns
module fcs_flash_model (
	input wire ce_n_in,
	input wire we_n_in,
	input wire oe_n_in,
	input wire [21:0] a_in,
	input wire [15:0] dq_in,
	output wire [15:0] dq_out,
	output wire rb_low_out
);
	// arbitrary id codes
	localparam [15:0] MK = 16'h00C3, D1 = 16'h0011, D2 = 16'h0022;
	localparam [15:0] D3 = 16'h0033, LK = 16'h0040;
	reg [15:0] mem [0:255];
	reg [15:0] rd;
	reg [2:0] st = 3'h0, n = 3'h0;
	reg [1:0] bp = 2'h0;
	reg [9:0] es = 10'h000;
	reg ids = 1'b0, busy = 1'b0, t1 = 1'b0, t2 = 1'b0;
	integer i;
	wire rdg = !ce_n_in && !oe_n_in;
	wire wrg = !ce_n_in && !we_n_in;
	wire hit = (st == 3'h3 || st == 3'h4) && a_in[21:12] == es;
	initial for (i = 0; i < 256; i = i + 1) mem[i] = 16'hFFFF;
	assign rb_low_out = busy || st == 3'h3;
	// released bus shows the inverse, never a stale value
	assign dq_out = rdg ? rd : ~rd;
	always @* begin
		rd = mem[a_in[7:0]];
		if (hit) rd = {8'h00, st == 3'h4, t1, 3'h0, t2, 2'h0};
		if (st == 3'h1)
			case (a_in[7:0])
			8'h00: rd = MK;
			8'h01: rd = D1;
			8'h0E: rd = D2;
			8'h0F: rd = D3;
			8'h03: rd = LK;
			default: rd = 16'h0000;
			endcase
	end
	always @(posedge rdg) if (hit) begin
		t2 = ~t2;
		if (st == 3'h3) t1 = ~t1;
	end
	// latched on the first rising strobe; writes while blocked are lost
	always @(negedge wrg) wr(a_in, dq_in);
	task prog(input [7:0] pa, input [15:0] pd);
		begin
			busy = 1'b1;
			mem[pa] = mem[pa] & pd;
			#4000 busy = 1'b0;
		end
	endtask
	task wr(input [21:0] ad, input [15:0] d);
		reg [10:0] u;
		reg [7:0] c;
		begin
			u = ad[10:0];
			c = d[7:0];
			if (st == 3'h3) begin
				if (c == 8'hB0) #12000 st = 3'h4;
			end else if (st == 3'h2) begin
				if (bp == 2'h1) prog(ad[7:0], d);
				if (bp == 2'h2 && c == 8'h00) st = 3'h0;
				bp = bp != 2'h0 ? 2'h0 : c == 8'hA0 ? 2'h1 :
					c == 8'h90 ? 2'h2 : 2'h0;
			end else if (c == 8'hF0) begin
				if (st == 3'h1) st = ids ? 3'h4 : 3'h0;
				ids = 1'b0;
				n = 3'h0;
			end else if (st == 3'h4 && n == 3'h0 && c == 8'h30) begin
				st = 3'h3;
			end else if (n == 3'h3) begin
				n = 3'h0;
				prog(ad[7:0], d);
			end else if (n == 3'h6) begin
				n = 3'h0;
				es = ad[21:12];
				if (c == 8'h30) st = 3'h3;
				if (c == 8'h10) begin
					busy = 1'b1;
					#100000 for (i = 0; i < 256; i = i + 1) mem[i] = 16'hFFFF;
					busy = 1'b0;
				end
			end else if (n[1:0] == 2'h0 && u == 11'h555 && c == 8'hAA)
				n = n + 3'h1;
			else if (n[1:0] == 2'h1 && u == 11'h2AA && c == 8'h55)
				n = n + 3'h1;
			else if (n == 3'h2 && u == 11'h555) begin
				n = c == 8'hA0 ? 3'h3 : c == 8'h80 ? 3'h4 : 3'h0;
				ids = ids || (c == 8'h90 && st == 3'h4);
				if (c == 8'h90) st = 3'h1;
				if (c == 8'h20) st = 3'h2;
			end else
				n = 3'h0;
		end
	endtask
endmodule // fcs_flash_model

// file: dv/test_fcs_host.sv
`timescale 1ns/1ns
module test_fcs_host;
	localparam [21:0] SA = 22'h080000;
	reg CLK_IN = 1'b0, RESET_IN = 1'b1, REQ_IN = 1'b0;
	reg [3:0] OP_IN = 4'h0;
	reg [21:0] ADDR_IN = 22'h000000;
	reg [15:0] DATA_IN = 16'h0000;
	wire [15:0] RDATA_OUT, FLASH_DQ_OUT, m_dq;
	wire [21:0] FLASH_A_OUT;
	wire BUSY_OUT, DONE_OUT, FLASH_CE_N_OUT, FLASH_WE_N_OUT, FLASH_OE_N_OUT;
	wire FLASH_DQ_OE_OUT, READY_OUT, SUSPENDED_OUT, rb_low;
	wire [15:0] FLASH_DQ_IN = FLASH_DQ_OE_OUT ? FLASH_DQ_OUT : m_dq;
	wire READY_BUSY_N_IN = rb_low ? 1'b0 : 1'b1;
	integer err_total = 0, total_checks = 0, cyc = 0;
	always #20 CLK_IN = ~CLK_IN;
	fcs_host dut (.CLK_IN, .RESET_IN, .REQ_IN, .OP_IN, .ADDR_IN, .DATA_IN,
		.BUSY_OUT, .DONE_OUT, .RDATA_OUT, .FLASH_CE_N_OUT, .FLASH_WE_N_OUT,
		.FLASH_OE_N_OUT, .FLASH_A_OUT, .FLASH_DQ_OUT, .FLASH_DQ_OE_OUT,
		.FLASH_DQ_IN, .READY_BUSY_N_IN, .READY_OUT, .SUSPENDED_OUT);
	fcs_flash_model mdl (.ce_n_in(FLASH_CE_N_OUT), .we_n_in(FLASH_WE_N_OUT),
		.oe_n_in(FLASH_OE_N_OUT), .a_in(FLASH_A_OUT), .dq_in(FLASH_DQ_IN),
		.dq_out(m_dq), .rb_low_out(rb_low));
	task close_out;
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input [39:0] nm, input [15:0] e, input [15:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("MISMATCH %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task op(input [3:0] o, input [21:0] a, input [15:0] d);
		integer k;
		begin
			@(negedge CLK_IN);
			{REQ_IN, OP_IN, ADDR_IN, DATA_IN} = {1'b1, o, a, d};
			@(negedge CLK_IN);
			REQ_IN = 1'b0;
			for (k = 0; k < 900 && DONE_OUT !== 1'b1; k = k + 1)
				@(negedge CLK_IN);
			if (DONE_OUT !== 1'b1) begin
				err_total = err_total + 1;
				$display("MISMATCH done exp 1 got %b", DONE_OUT);
			end
		end
	endtask
	task rdc(input [3:0] o, input [21:0] a, input [15:0] e);
		begin
			op(o, a, 16'h0000);
			chk("rdata", e, RDATA_OUT);
		end
	endtask
	// busy first, then ready again
	task wrdy;
		integer k;
		begin
			for (k = 0; k < 50 && READY_OUT !== 1'b0; k = k + 1)
				@(negedge CLK_IN);
			for (k = 0; k < 4000 && READY_OUT !== 1'b1; k = k + 1)
				@(negedge CLK_IN);
			if (READY_OUT !== 1'b1) begin
				err_total = err_total + 1;
				$display("MISMATCH ready exp 1 got %b", READY_OUT);
			end
		end
	endtask
	always @(posedge CLK_IN) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			close_out;
		end
	end
	initial begin
		repeat (5) @(negedge CLK_IN);
		RESET_IN = 1'b0;
		rdc(4'h1, 22'h000000, mdl.MK);
		rdc(4'h1, 22'h000001, mdl.D1);
		rdc(4'h1, 22'h00000E, mdl.D2);
		rdc(4'h1, 22'h00000F, mdl.D3);
		rdc(4'h1, 22'h000003, mdl.LK);
		rdc(4'h1, 22'h001002, 16'h0000);
		op(4'h0, 22'h3FFFFF, 16'h0000);
		op(4'h2, 22'h000010, 16'h1234);
		wrdy;
		rdc(4'hA, 22'h000010, 16'h1234);
		op(4'h3, 22'h000000, 16'h0000);
		op(4'h6, 22'h000011, 16'h5A5A);
		wrdy;
		op(4'h7, 22'h000000, 16'h0000);
		rdc(4'hA, 22'h000011, 16'h5A5A);
		op(4'h4, 22'h000000, 16'h0000);
		op(4'h8, 22'h000000, 16'h0000);
		wrdy;
		rdc(4'hA, 22'h000010, 16'hFFFF);
		op(4'h9, 22'h000000, 16'h0000);
		chk("susp", 16'h0000, {15'h0, SUSPENDED_OUT});
		op(4'h5, SA, 16'h0000);
		rdc(4'hA, SA, 16'h0044);
		rdc(4'hA, SA, 16'h0000);
		op(4'h8, SA, 16'h0000);
		chk("susp", 16'h0001, {15'h0, SUSPENDED_OUT});
		chk("ready", 16'h0001, {15'h0, READY_OUT});
		rdc(4'hA, SA, 16'h0084);
		rdc(4'hA, SA, 16'h0080);
		op(4'h2, 22'h000020, 16'h00FF);
		wrdy;
		rdc(4'hA, 22'h000020, 16'h00FF);
		rdc(4'h1, SA, mdl.MK);
		op(4'h0, 22'h000000, 16'h0000);
		rdc(4'hA, SA, 16'h0084);
		op(4'h9, SA, 16'h0000);
		op(4'h9, SA, 16'h0000);
		chk("ready", 16'h0000, {15'h0, READY_OUT});
		op(4'h8, SA, 16'h0000);
		chk("ready", 16'h0001, {15'h0, READY_OUT});
		close_out;
	end
endmodule // test_fcs_host
